// ==== rtl/acmc_pkg.sv ====
/*
 Constants, field layouts and carrier types for the accumulator motion
 command block. Assumes a single system clock and a nine byte frame stream.
*/
package acmc_pkg;
   // Instruction numbers handled here
   localparam logic [7:0] MOVE_TO_ACC_POSITION = 8'h2E;
   localparam logic [7:0] MOVE_INDEXED_ACC_POSITION = 8'h2F;
   localparam logic [7:0] ROTATE_LEFT_ACC_VELOCITY = 8'h32;
   localparam logic [7:0] ROTATE_RIGHT_ACC_VELOCITY = 8'h33;
   // Move type field
   localparam logic [7:0] ABSOLUTE_TYPE = 8'h00;
   localparam logic [7:0] RELATIVE_TYPE = 8'h01;
   localparam logic [7:0] STORED_COORDINATE_TYPE = 8'h02;
   // Axis count and limits
   localparam int NUM_AXES = 6;
   localparam logic [7:0] MAX_AXIS = 8'h05;
   // Reply status codes
   localparam logic [7:0] STATUS_OK = 8'h64;
   localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
   localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
   // Frame layout
   localparam logic [3:0] FRAME_LAST = 4'h8;
   localparam logic [7:0] MODULE_ADDR_RST = 8'h01;
   // Axis motion modes and directions
   localparam logic MODE_POSITION = 1'b0;
   localparam logic MODE_VELOCITY = 1'b1;
   localparam logic DIR_DECREASE = 1'b0;
   localparam logic DIR_INCREASE = 1'b1;
   // APB byte offsets
   localparam logic [11:0] ACC_OFS = 12'h000;
   localparam logic [11:0] XIDX_OFS = 12'h004;
   localparam logic [11:0] STATUS_OFS = 12'h008;
   localparam logic [11:0] STORED_COORDINATE_TYPE_ADDR_OFS = 12'h00C;
   localparam logic [11:0] STORED_COORDINATE_TYPE_DATA_OFS = 12'h010;
   localparam logic [11:0] MODADDR_OFS = 12'h014;
   // Status register field positions
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_MODE_LSB = 8;
   localparam int ST_LAST_LSB = 16;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] instr;
      logic [7:0] typ;
      logic [7:0] motor;
      logic [31:0] value;
   } acmc_frame_t;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] instr;
      logic [31:0] value;
   } acmc_reply_t;

   typedef struct packed {
      logic [2:0] axis;
      logic mode;
      logic dir;
      logic signed [31:0] tpos;
      logic [31:0] tvel;
   } acmc_axis_cmd_t;
endpackage

// ==== rtl/acmc_frame_rx.sv ====
/*
 Nine byte frame collector with modulo-256 checksum check.
 Assumes bytes arrive from logic on the same clock, one per valid pulse.
*/
`timescale 1ns/1ps
module acmc_frame_rx (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Byte stream
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_valid_i,
   // Collected frame
   output acmc_pkg::acmc_frame_t frame_o,
   output logic frame_valid_o,
   output logic sum_ok_o
);
   logic [3:0] idx;
   logic [7:0] sum;
   logic [63:0] body;

   // Byte order: address, instruction, type, motor, value MSB first, sum
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         idx <= 4'h0;
         sum <= 8'h00;
         body <= 64'h0;
      end else if (rx_valid_i) begin
         if (idx == acmc_pkg::FRAME_LAST) begin
            idx <= 4'h0;
            sum <= 8'h00;
         end else begin
            idx <= idx + 4'h1;
            sum <= sum + rx_byte_i;
            body <= {body[55:0], rx_byte_i};
         end
      end
   end

   // Frame out on the checksum byte
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         frame_o <= '0;
         frame_valid_o <= 1'b0;
         sum_ok_o <= 1'b0;
      end else begin
         frame_valid_o <= rx_valid_i && (idx == acmc_pkg::FRAME_LAST);
         if (rx_valid_i && (idx == acmc_pkg::FRAME_LAST)) begin
            frame_o <= body;
            sum_ok_o <= (sum == rx_byte_i);
         end
      end
   end
endmodule // acmc_frame_rx

// ==== rtl/acmc_stored_coordinate_type_mem.sv ====
/*
 Stored coordinate memory, 256 words of 32 bits, registered read data.
 Assumes one writer and one reader on the same clock.
*/
`timescale 1ns/1ps
module acmc_stored_coordinate_type_mem (
   // Clock
   input wire logic ref_clk_i,
   // Write port
   input wire logic wr_en_i,
   input wire logic [7:0] wr_addr_i,
   input wire logic [31:0] wr_data_i,
   // Read port
   input wire logic rd_en_i,
   input wire logic [7:0] rd_addr_i,
   output logic [31:0] rd_data_o
);
   logic [31:0] mem [256];

   // Write and registered read
   always_ff @(posedge ref_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      if (rd_en_i) begin
         rd_data_o <= mem[rd_addr_i];
      end
   end
endmodule // acmc_stored_coordinate_type_mem

// ==== rtl/acmc_motion_cmd.sv ====
/*
 Accumulator motion command interpreter: decodes frames, updates axis
 targets and modes, answers each addressed frame of its four instructions. Registers over APB.
 Assumes a ramp generator consumes axis_cmd_o and reports positions.
*/
// Design decisions made here: the register offsets and the APB slave port.
// What this block does
// - Absolute move: accumulator becomes target position
// - Type 0 absolute, 1 relative, 2 coordinate
// - Reply right after interpretation, not completion
// - Accept new commands while axes travel
// - Ramp settings come from axis parameters
// - Halt or rotate aborts positioning move
// - Relative: actual position plus accumulator offset
// - Coordinate: motor field selects stored entry
// - Position arithmetic wraps at 32 bits
// - Move copies accumulator to target position
// - Indexed move takes axis from X register
// - Indexed move writes selected axis target
// - Rotate selects velocity mode, ignores type, value
// - Rotate copies accumulator to target velocity
// - Left rotation decreases position counter
// - Right rotation increases position counter
// - Rotate accumulator is microsteps per second
// - Direct mode reply status 100, value don't-care
`timescale 1ns/1ps
module acmc_motion_cmd (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Command byte stream
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_valid_i,
   // Halt or rotate from the rest of the interpreter
   input wire logic halt_req_i,
   input wire logic [2:0] halt_axis_i,
   // Actual positions from the ramp generator
   input wire logic [acmc_pkg::NUM_AXES-1:0][31:0] act_pos_i,
   // Axis update towards the ramp generator
   output acmc_pkg::acmc_axis_cmd_t axis_cmd_o,
   output logic axis_upd_o,
   output logic abort_o,
   output logic [2:0] abort_axis_o,
   // Reply
   output acmc_pkg::acmc_reply_t reply_o,
   output logic reply_valid_o
);
   typedef enum logic [1:0] {
      ACMC_IDLE = 2'b00,
      ACMC_FETCH = 2'b01,
      ACMC_EXEC = 2'b11,
      ACMC_REPLY = 2'b10
   } acmc_state_t;

   acmc_state_t state;
   acmc_state_t next_state;
   acmc_pkg::acmc_frame_t frame;
   acmc_pkg::acmc_frame_t cmd;
   logic frame_valid;
   logic sum_ok;
   logic signed [31:0] acc;
   logic [7:0] xidx;
   logic [7:0] stored_coordinate_type_addr;
   logic [7:0] mod_addr;
   logic [7:0] last_status;
   logic [acmc_pkg::NUM_AXES-1:0] mode;
   logic [2:0] axis;
   logic [31:0] stored_coordinate_type_data;
   logic apb_wr;
   logic apb_setup;
   logic mapped;
   logic ours;
   logic indexed;
   logic rotate;
   logic [7:0] sel_axis;
   logic value_ok;
   logic signed [31:0] next_tpos;

   acmc_frame_rx u_rx (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .rx_byte_i(rx_byte_i),
      .rx_valid_i(rx_valid_i),
      .frame_o(frame),
      .frame_valid_o(frame_valid),
      .sum_ok_o(sum_ok)
   );

   acmc_stored_coordinate_type_mem u_mem (
      .ref_clk_i(ref_clk_i),
      .wr_en_i(apb_wr && (paddr == acmc_pkg::STORED_COORDINATE_TYPE_DATA_OFS)),
      .wr_addr_i(stored_coordinate_type_addr),
      .wr_data_i(pwdata),
      .rd_en_i(state == ACMC_FETCH),
      .rd_addr_i(cmd.motor),
      .rd_data_o(stored_coordinate_type_data)
   );

   // APB decode
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pready && pwrite;
   assign mapped = (paddr == acmc_pkg::ACC_OFS) || (paddr == acmc_pkg::XIDX_OFS) ||
      (paddr == acmc_pkg::STATUS_OFS) || (paddr == acmc_pkg::STORED_COORDINATE_TYPE_ADDR_OFS) ||
      (paddr == acmc_pkg::STORED_COORDINATE_TYPE_DATA_OFS) || (paddr == acmc_pkg::MODADDR_OFS);

   // Ready and error after each setup cycle, read data captured at setup
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup && !mapped;
         if (apb_setup && !pwrite) begin
            case (paddr)
               acmc_pkg::ACC_OFS: prdata <= acc;
               acmc_pkg::XIDX_OFS: prdata <= {24'h000000, xidx};
               acmc_pkg::STATUS_OFS: begin
                  prdata <= 32'h0000_0000;
                  prdata[acmc_pkg::ST_BUSY_BIT] <= (state != ACMC_IDLE);
                  prdata[acmc_pkg::ST_MODE_LSB +: acmc_pkg::NUM_AXES] <= mode;
                  prdata[acmc_pkg::ST_LAST_LSB +: 8] <= last_status;
               end
               acmc_pkg::STORED_COORDINATE_TYPE_ADDR_OFS: prdata <= {24'h000000, stored_coordinate_type_addr};
               acmc_pkg::MODADDR_OFS: prdata <= {24'h000000, mod_addr};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Software registers: accumulator, X index, coordinate pointer, address
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         acc <= 32'sh0000_0000;
         xidx <= 8'h00;
         stored_coordinate_type_addr <= 8'h00;
         mod_addr <= acmc_pkg::MODULE_ADDR_RST;
      end else if (apb_wr) begin
         case (paddr)
            acmc_pkg::ACC_OFS: acc <= pwdata;
            acmc_pkg::XIDX_OFS: xidx <= pwdata[7:0];
            acmc_pkg::STORED_COORDINATE_TYPE_ADDR_OFS: stored_coordinate_type_addr <= pwdata[7:0];
            acmc_pkg::MODADDR_OFS: mod_addr <= pwdata[7:0];
            default: stored_coordinate_type_addr <= stored_coordinate_type_addr;
         endcase
      end
   end

   // Incoming frame classification
   assign indexed = (frame.instr == acmc_pkg::MOVE_INDEXED_ACC_POSITION);
   assign rotate = (frame.instr == acmc_pkg::ROTATE_LEFT_ACC_VELOCITY) ||
      (frame.instr == acmc_pkg::ROTATE_RIGHT_ACC_VELOCITY);
   assign ours = rotate || indexed || (frame.instr == acmc_pkg::MOVE_TO_ACC_POSITION);
   // Indexed and coordinate moves pick the axis from the X register
   assign sel_axis = (indexed || (!rotate && frame.typ == acmc_pkg::STORED_COORDINATE_TYPE)) ?
      xidx : frame.motor;
   // Rotations ignore the type field
   assign value_ok = (sel_axis <= acmc_pkg::MAX_AXIS) &&
      (rotate || (frame.typ <= acmc_pkg::STORED_COORDINATE_TYPE));

   // Sequencer
   always_comb begin
      next_state = state;
      case (state)
         ACMC_IDLE: begin
            if (frame_valid && (frame.addr == mod_addr) && ours) begin
               next_state = (sum_ok && value_ok) ? ACMC_FETCH : ACMC_REPLY;
            end
         end
         ACMC_FETCH: next_state = ACMC_EXEC;
         ACMC_EXEC: next_state = ACMC_REPLY;
         ACMC_REPLY: next_state = ACMC_IDLE;
         default: next_state = ACMC_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state <= ACMC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Latch the command and its axis
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cmd <= '0;
         axis <= 3'h0;
      end else if (state == ACMC_IDLE && frame_valid) begin
         cmd <= frame;
         axis <= sel_axis[2:0];
      end
   end

   // New target position, wrapping at 32 bits
   always_comb begin
      case (cmd.typ)
         acmc_pkg::RELATIVE_TYPE: next_tpos = act_pos_i[axis] + acc;
         acmc_pkg::STORED_COORDINATE_TYPE: next_tpos = stored_coordinate_type_data;
         default: next_tpos = acc;
      endcase
   end

   // Axis update; ramp limits stay with the ramp generator's parameters
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         axis_cmd_o <= '0;
         axis_upd_o <= 1'b0;
         mode <= '0;
      end else begin
         axis_upd_o <= (state == ACMC_EXEC);
         if (state == ACMC_EXEC) begin
            axis_cmd_o.axis <= axis;
            if (cmd.instr == acmc_pkg::ROTATE_LEFT_ACC_VELOCITY ||
                cmd.instr == acmc_pkg::ROTATE_RIGHT_ACC_VELOCITY) begin
               axis_cmd_o.mode <= acmc_pkg::MODE_VELOCITY;
               mode[axis] <= acmc_pkg::MODE_VELOCITY;
               axis_cmd_o.tvel <= acc;
               axis_cmd_o.dir <= (cmd.instr == acmc_pkg::ROTATE_RIGHT_ACC_VELOCITY) ?
                  acmc_pkg::DIR_INCREASE : acmc_pkg::DIR_DECREASE;
            end else begin
               axis_cmd_o.mode <= acmc_pkg::MODE_POSITION;
               mode[axis] <= acmc_pkg::MODE_POSITION;
               axis_cmd_o.tpos <= next_tpos;
            end
         end else if (halt_req_i) begin
            mode[halt_axis_i] <= acmc_pkg::MODE_VELOCITY;
         end
      end
   end

   // Abort a positioning move on halt or rotation of the same axis
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         abort_o <= 1'b0;
         abort_axis_o <= 3'h0;
      end else if (state == ACMC_EXEC && cmd.instr[4] &&
                   mode[axis] == acmc_pkg::MODE_POSITION) begin
         abort_o <= 1'b1;
         abort_axis_o <= axis;
      end else begin
         abort_o <= halt_req_i && (mode[halt_axis_i] == acmc_pkg::MODE_POSITION);
         abort_axis_o <= halt_axis_i;
      end
   end

   // Reply once interpreted; motion completion is never awaited
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         reply_o <= '0;
         reply_valid_o <= 1'b0;
         last_status <= 8'h00;
      end else begin
         reply_valid_o <= (next_state == ACMC_REPLY);
         if (state == ACMC_IDLE && next_state == ACMC_REPLY) begin
            reply_o.status <= sum_ok ? acmc_pkg::STATUS_BAD_VALUE : acmc_pkg::STATUS_BAD_SUM;
            reply_o.instr <= frame.instr;
            reply_o.value <= 32'h0000_0000;
            last_status <= sum_ok ? acmc_pkg::STATUS_BAD_VALUE : acmc_pkg::STATUS_BAD_SUM;
         end else if (state == ACMC_EXEC) begin
            reply_o.status <= acmc_pkg::STATUS_OK;
            reply_o.instr <= cmd.instr;
            reply_o.value <= 32'h0000_0000;
            last_status <= acmc_pkg::STATUS_OK;
         end
      end
   end

   // Checks
   chk_ok_reply: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_EXEC |=> reply_valid_o && reply_o.status == acmc_pkg::STATUS_OK)
      else $error("ok reply missing after execution");
   chk_reply_time: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_IDLE && frame_valid && frame.addr == mod_addr && ours
      |-> ##[1:3] reply_valid_o)
      else $error("reply not within three cycles");
   chk_abs_target: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_EXEC && !cmd.instr[4] && cmd.typ == acmc_pkg::ABSOLUTE_TYPE
      |=> axis_upd_o && axis_cmd_o.tpos == $past(acc))
      else $error("absolute target differs from accumulator");
   chk_rel_wrap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_EXEC && !cmd.instr[4] && cmd.typ == acmc_pkg::RELATIVE_TYPE
      |=> axis_cmd_o.tpos == 32'($past(act_pos_i[axis]) + $past(acc)))
      else $error("relative target not wrapped sum");
   chk_vel_copy: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_EXEC && cmd.instr[4]
      |=> axis_cmd_o.mode == acmc_pkg::MODE_VELOCITY && axis_cmd_o.tvel == $past(acc))
      else $error("rotation did not load velocity");
   chk_dir_left: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_EXEC && cmd.instr == acmc_pkg::ROTATE_LEFT_ACC_VELOCITY
      |=> axis_cmd_o.dir == acmc_pkg::DIR_DECREASE)
      else $error("left rotation direction wrong");
   chk_dir_right: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_EXEC && cmd.instr == acmc_pkg::ROTATE_RIGHT_ACC_VELOCITY
      |=> axis_cmd_o.dir == acmc_pkg::DIR_INCREASE)
      else $error("right rotation direction wrong");
   chk_bad_sum: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_IDLE && frame_valid && !sum_ok
      |=> !axis_upd_o ##1 !axis_upd_o)
      else $error("bad checksum frame executed");
   chk_idx_axis: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_EXEC && cmd.instr == acmc_pkg::MOVE_INDEXED_ACC_POSITION
      |=> axis_cmd_o.axis == $past(xidx[2:0]))
      else $error("indexed move used wrong axis");
   chk_move_mode: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_EXEC && !cmd.instr[4]
      |=> axis_upd_o && axis_cmd_o.mode == acmc_pkg::MODE_POSITION)
      else $error("move did not select position mode");
   chk_stored_coordinate_type_target: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_EXEC && !cmd.instr[4] && cmd.typ == acmc_pkg::STORED_COORDINATE_TYPE
      |=> axis_cmd_o.tpos == $past(stored_coordinate_type_data))
      else $error("coordinate target differs from stored entry");
   chk_rot_mode: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_EXEC && cmd.instr[4] |=> mode[$past(axis)] == acmc_pkg::MODE_VELOCITY)
      else $error("rotation left axis in position mode");
   chk_rot_abort: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_EXEC && cmd.instr[4] && mode[axis] == acmc_pkg::MODE_POSITION
      |=> abort_o && abort_axis_o == $past(axis))
      else $error("rotation did not abort positioning");
   chk_halt_abort: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      halt_req_i && state != ACMC_EXEC && mode[halt_axis_i] == acmc_pkg::MODE_POSITION
      |=> abort_o && abort_axis_o == $past(halt_axis_i))
      else $error("halt did not abort positioning");
   chk_bad_reply: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_IDLE && frame_valid && frame.addr == mod_addr && ours && !sum_ok
      |=> reply_valid_o && reply_o.status == acmc_pkg::STATUS_BAD_SUM)
      else $error("bad checksum not reported");
   chk_foreign_frame: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == ACMC_IDLE && frame_valid && frame.addr != mod_addr |=> !reply_valid_o)
      else $error("frame for another address answered");
   chk_reply_free: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      reply_valid_o |-> state == ACMC_REPLY ##1 state == ACMC_IDLE)
      else $error("interpreter not free after reply");
   cov_move: cover property (@(posedge ref_clk_i) state == ACMC_EXEC && !cmd.instr[4]);
   cov_halt: cover property (@(posedge ref_clk_i) halt_req_i ##1 abort_o);
   cov_rotate: cover property (@(posedge ref_clk_i) abort_o && state == ACMC_REPLY);
   cov_bad: cover property (@(posedge ref_clk_i)
      reply_valid_o && reply_o.status == acmc_pkg::STATUS_BAD_SUM);
endmodule // acmc_motion_cmd

// ==== testbench/acmc_host_model.sv ====
/*
 Host side model: sends nine byte command frames with their checksum.
 Assumes the bench pulses send_i only while busy_o is low, same clock.
*/
`timescale 1ns/1ps
module acmc_host_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Frame request from the bench
   input wire logic send_i,
   input acmc_pkg::acmc_frame_t frame_i,
   input wire logic bad_sum_i,
   input wire logic [1:0] gap_i,
   // Byte stream towards the block
   output logic [7:0] rx_byte_o,
   output logic rx_valid_o,
   output logic busy_o
);
   logic [71:0] bytes_q;
   logic [3:0] idx;
   logic [1:0] wait_cnt;
   logic [7:0] sum;

   // Modulo-256 sum of the eight bytes before the checksum
   always_comb begin
      sum = 8'h00;
      for (int i = 0; i < 8; i++) begin
         sum = sum + frame_i[63-8*i -: 8];
      end
   end

   // Byte sequencer; idle line toggles so stale data never looks valid
   always_ff @(posedge ref_clk_i) begin
      rx_valid_o <= 1'b0;
      if (rst_i) begin
         busy_o <= 1'b0;
         idx <= 4'h0;
         wait_cnt <= 2'h0;
         rx_byte_o <= 8'h00;
      end else if (send_i && !busy_o) begin
         bytes_q <= {frame_i, sum ^ {7'h00, bad_sum_i}};
         busy_o <= 1'b1;
         idx <= 4'h0;
         wait_cnt <= 2'h0;
      end else if (busy_o && wait_cnt == 2'h0) begin
         rx_byte_o <= bytes_q[71-8*idx -: 8];
         rx_valid_o <= 1'b1;
         wait_cnt <= gap_i;
         idx <= idx + 4'h1;
         busy_o <= (idx != 4'h8);
      end else begin
         rx_byte_o <= ~rx_byte_o;
         wait_cnt <= (wait_cnt == 2'h0) ? 2'h0 : wait_cnt - 2'h1;
      end
   end
endmodule // acmc_host_model

// ==== testbench/tb_accumulator_motion_commands.sv ====
/*
 Self-checking bench for the accumulator motion command block.
 Assumes the host model feeds frames and APB tasks set the registers.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
   error_cnt++; $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module tb_accumulator_motion_commands;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, rx_valid, busy, axis_upd, abort, reply_valid;
   logic send = 1'b0, bad_sum = 1'b0, halt_req = 1'b0;
   logic [1:0] gap = 2'h0;
   logic [2:0] halt_axis = 3'h0, abort_axis;
   logic [7:0] rx_byte, ins, ty, mo, modaddr = 8'h01, last_st = 8'h00;
   logic [5:0] mode_m = 6'h00;
   logic [acmc_pkg::NUM_AXES-1:0][31:0] act_pos = '0;
   acmc_pkg::acmc_frame_t frame = '0;
   acmc_pkg::acmc_axis_cmd_t axis_cmd;
   acmc_pkg::acmc_reply_t reply;
   int seed = 50, error_cnt = 0, cmp_count = 0, cyc = 0;
   int stored_coordinate_type_m [int];
   int act_m [6] = '{0, 0, 0, 0, 0, 0};
   int cidx [4] = '{0, 7, 128, 255};
   logic [7:0] ins_tab [4] = '{8'h2E, 8'h2F, 8'h32, 8'h33};

   // 125 MHz clock
   initial begin
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   acmc_motion_cmd i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_byte_i(rx_byte),
      .rx_valid_i(rx_valid), .halt_req_i(halt_req), .halt_axis_i(halt_axis),
      .act_pos_i(act_pos), .axis_cmd_o(axis_cmd), .axis_upd_o(axis_upd),
      .abort_o(abort), .abort_axis_o(abort_axis), .reply_o(reply),
      .reply_valid_o(reply_valid));

   acmc_host_model i_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .send_i(send),
      .frame_i(frame), .bad_sum_i(bad_sum), .gap_i(gap), .rx_byte_o(rx_byte),
      .rx_valid_o(rx_valid), .busy_o(busy));

   // Verdict and end of run
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // One APB transfer; read data and error land in rd and err
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      do @(posedge ref_clk_i); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   // Sends one frame and checks the reply against the reference model
   task automatic cmd(input logic [7:0] ad, i, t, m, input logic [31:0] accv,
                      input logic [7:0] xv, input logic bad);
      int ax, n;
      logic [7:0] st;
      logic [31:0] tp;
      logic seen, ab;
      apb(1'b1, acmc_pkg::ACC_OFS, accv);
      apb(1'b1, acmc_pkg::XIDX_OFS, {24'h0, xv});
      for (int k = 0; k < 6; k++) act_pos[k] <= act_m[k];
      ax = (i == 8'h2F || (!i[4] && t == 8'h02)) ? xv : m;
      st = bad ? acmc_pkg::STATUS_BAD_SUM : (ax > 5 || (!i[4] && t > 8'h02)) ?
           acmc_pkg::STATUS_BAD_VALUE : acmc_pkg::STATUS_OK;
      tp = t == 8'h00 ? accv : t == 8'h01 ? act_m[ax % 6] + accv : stored_coordinate_type_m[m];
      ab = i[4] && !mode_m[ax % 6];
      frame <= {ad, i, t, m, 32'($random(seed))};
      bad_sum <= bad;
      gap <= 2'($random(seed));
      send <= 1'b1;
      @(posedge ref_clk_i);
      send <= 1'b0;
      seen = 1'b0;
      for (n = 0; n < 60 && !seen; n++) begin
         @(posedge ref_clk_i);
         if (reply_valid === 1'b1) begin
            seen = 1'b1;
            `CHK("status", st, reply.status)
            `CHK("instr", i, reply.instr)
            `CHK("update", st == acmc_pkg::STATUS_OK, axis_upd)
            if (st == acmc_pkg::STATUS_OK) begin
               `CHK("axis", 3'(ax), axis_cmd.axis)
               `CHK("mode", i[4], axis_cmd.mode)
               `CHK("abort", ab, abort)
               if (ab) `CHK("abort axis", 3'(ax), abort_axis)
               if (i[4]) begin
                  `CHK("velocity", accv, axis_cmd.tvel)
                  `CHK("direction", i[0], axis_cmd.dir)
               end else begin
                  `CHK("target", tp, axis_cmd.tpos)
               end
            end
         end
      end
      `CHK("reply seen", ad == modaddr && (i inside {ins_tab}), seen)
      if (seen && st == acmc_pkg::STATUS_OK) mode_m[ax] = i[4];
      if (seen) last_st = st;
      apb(1'b0, acmc_pkg::STATUS_OFS, 32'h0);
      `CHK("mode bits", mode_m, rd[13:8])
      `CHK("last status", last_st, rd[23:16])
      `CHK("busy", 1'b0, rd[0])
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      apb(1'b0, acmc_pkg::MODADDR_OFS, 32'h0);
      `CHK("module addr reset", 32'h1, rd)
      apb(1'b0, acmc_pkg::ACC_OFS, 32'h0);
      `CHK("acc reset", 32'h0, rd)
      apb(1'b1, 12'h100, 32'h0);
      `CHK("unmapped error", 1'b1, err)
      foreach (cidx[k]) begin
         stored_coordinate_type_m[cidx[k]] = $random(seed);
         apb(1'b1, acmc_pkg::STORED_COORDINATE_TYPE_ADDR_OFS, cidx[k]);
         apb(1'b1, acmc_pkg::STORED_COORDINATE_TYPE_DATA_OFS, stored_coordinate_type_m[cidx[k]]);
      end
      $display("test registers done");
      // Every instruction, the moves with every move type, random operands
      for (int k = 0; k < 36; k++) begin
         for (int j = 0; j < 6; j++) act_m[j] = $random(seed);
         ins = ins_tab[k % 4];
         ty = ins[4] ? 8'($random(seed)) : 8'((k / 4) % 3);
         mo = (!ins[4] && ty == 8'h02) ? 8'(cidx[$unsigned($random(seed)) % 4]) :
              (ins == 8'h2F) ? 8'($random(seed)) : 8'($unsigned($random(seed)) % 6);
         cmd(modaddr, ins, ty, mo, $random(seed), 8'($unsigned($random(seed)) % 6), 1'b0);
      end
      $display("test random commands done");
      // Relative move past the largest positive position, then faults
      act_m[1] = 32'h7FFFFFFF;
      cmd(modaddr, 8'h2E, 8'h01, 8'h01, 32'h00000010, 8'h00, 1'b0);
      cmd(modaddr, 8'h2E, 8'h00, 8'h00, 32'h00000005, 8'h00, 1'b1);
      cmd(modaddr, 8'h32, 8'h00, 8'h06, 32'h00000005, 8'h00, 1'b0);
      cmd(modaddr, 8'h2F, 8'h03, 8'h00, 32'h00000005, 8'h00, 1'b0);
      // Halt request aborts a positioning move on the same axis
      cmd(modaddr, 8'h2E, 8'h00, 8'h02, 32'h00000100, 8'h00, 1'b0);
      halt_axis <= 3'h2;
      halt_req <= 1'b1;
      @(posedge ref_clk_i);
      halt_req <= 1'b0;
      @(posedge ref_clk_i);
      `CHK("halt abort", 1'b1, abort)
      `CHK("halt axis", 3'h2, abort_axis)
      mode_m[2] = 1'b1;
      cmd(modaddr, 8'h33, 8'h00, 8'h02, 32'h00000200, 8'h00, 1'b0);
      // Frames for another module address or an unknown instruction are ignored
      apb(1'b1, acmc_pkg::MODADDR_OFS, 32'h7);
      modaddr = 8'h07;
      cmd(8'h01, 8'h2E, 8'h00, 8'h03, 32'h00000300, 8'h00, 1'b0);
      cmd(8'h07, 8'h2E, 8'h00, 8'h03, 32'h00000400, 8'h00, 1'b0);
      cmd(8'h07, 8'h30, 8'h00, 8'h03, 32'h00000500, 8'h00, 1'b0);
      $display("test directed cases done");
      stop_test();
   end

   // Cuts a hung run short
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
   end
endmodule // tb_accumulator_motion_commands
